// ==== hdl/reconfig_cfg.svh ====
`ifndef RECONFIG_CFG_SVH
`define RECONFIG_CFG_SVH

// Register offsets (word index on the slave port)
`define OFF_TRIGGER    3'h0
`define OFF_SEL_WRITE  3'h1
`define OFF_READBACK   3'h2
`define OFF_BUSY       3'h3
`define OFF_WATCHDOG   3'h4
`define OFF_PREV_ONE   3'h5
`define OFF_PREV_TWO   3'h6
`define OFF_SEL_READ   3'h7

// Trigger register fields
`define BIT_RECONFIG   0
`define BIT_WD_RESET   1

// Image select fields
`define BIT_OVERRIDE   0
`define BIT_IMAGE      1
`define SEL_W          2

// Readback trigger fields
`define RB_WATCHDOG    0
`define RB_PREV_TWO    1
`define RB_PREV_ONE    2
`define RB_INPUT       3
`define RB_W           4

// Serial frame layout toward the upgrade block
`define XFER_LEN       34
`define XFER_CNT_W     6
`define XFER_LAST      6'h21
`define WD_COUNT_W     29
`define WD_MSB_LO      17
`define WD_MSB_HI      28
`define WD_EN_POS      29
`define WD_STATE_LO    30
`define WD_STATE_HI    33
`define WD_FIELD_W     17
`define PREV_W         8

`endif

// ==== hdl/reconfig_pkg.sv ====
`include "reconfig_cfg.svh"

package reconfig_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_SHIFT   = 2'b10,
    ST_UPDATE  = 2'b11
  } eng_state_t;

  typedef enum logic [2:0] {
    OP_RD_WD    = 3'b000,
    OP_RD_PREV2 = 3'b001,
    OP_RD_PREV1 = 3'b010,
    OP_RD_INPUT = 3'b011,
    OP_WR_INPUT = 3'b100
  } op_t;

  typedef logic [`XFER_LEN-1:0] frame_t;

endpackage : reconfig_pkg

// ==== hdl/xfer_if.sv ====
`timescale 1ns/100ps
`include "reconfig_cfg.svh"

interface xfer_if import reconfig_pkg::*; ();
  logic   start;
  op_t    op;
  frame_t wdata;
  logic   busy;
  logic   done;
  frame_t rdata;

  modport ctrl   (output start, op, wdata, input busy, done, rdata);
  modport engine (input start, op, wdata, output busy, done, rdata);
endinterface : xfer_if

// ==== hdl/upgrade_serial_engine.sv ====
`timescale 1ns/100ps
`include "reconfig_cfg.svh"

module upgrade_serial_engine import reconfig_pkg::*; (
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Controller side
  xfer_if.engine          x,
  // Upgrade block pins
  output logic            upgrade_block_clock,
  output logic            link_shift,
  output logic            link_capture,
  output logic            link_din,
  output logic [1:0]      link_reg_sel,
  input  wire logic       link_dout
);

  eng_state_t              state_ff;
  eng_state_t              nxt_state;
  logic                    div_ff;
  frame_t                  sr_ff;
  frame_t                  nxt_sr;
  logic [`XFER_CNT_W-1:0]  cnt_ff;
  logic [`XFER_CNT_W-1:0]  nxt_cnt;
  op_t                     op_ff;
  logic                    done_ff;
  logic                    nxt_done;

  // Steps happen on the falling edge of the link clock
  wire tick = ce & div_ff;
  wire last = (cnt_ff == `XFER_LAST);
  wire take = ce & x.start & (state_ff == ST_IDLE);

  always_comb begin
    nxt_state = state_ff;
    nxt_sr    = sr_ff;
    nxt_cnt   = cnt_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_sr    = x.wdata;
          nxt_cnt   = '0;
          nxt_state = x.op[2] ? ST_SHIFT : ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        if (tick) nxt_state = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (tick) begin
          nxt_sr  = {link_dout, sr_ff[`XFER_LEN-1:1]};
          nxt_cnt = cnt_ff + 1'b1;
          if (last) begin
            nxt_state = op_ff[2] ? ST_UPDATE : ST_IDLE;
            nxt_done  = ~op_ff[2];
          end
        end
      end
      ST_UPDATE: begin
        if (tick) begin
          nxt_state = ST_IDLE;
          nxt_done  = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff   <= 1'b0;
      state_ff <= ST_IDLE;
      sr_ff    <= '0;
      cnt_ff   <= '0;
      op_ff    <= OP_RD_WD;
      done_ff  <= 1'b0;
    end else if (ce) begin
      div_ff   <= ~div_ff;
      state_ff <= nxt_state;
      sr_ff    <= nxt_sr;
      cnt_ff   <= nxt_cnt;
      done_ff  <= nxt_done;
      if (take) op_ff <= x.op;
    end
  end

  assign upgrade_block_clock = div_ff;
  assign link_shift          = (state_ff == ST_SHIFT);
  assign link_capture        = (state_ff == ST_CAPTURE) | (state_ff == ST_SHIFT);
  assign link_din            = sr_ff[0];
  assign link_reg_sel        = op_ff[1:0] | {2{op_ff[2]}};
  assign x.busy              = (state_ff != ST_IDLE);
  assign x.done              = done_ff;
  assign x.rdata             = sr_ff;

  a_clock_half: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> (upgrade_block_clock != $past(upgrade_block_clock)))
    else $error("link clock did not toggle");

endmodule : upgrade_serial_engine

// ==== hdl/dual_image_reconfig_control.sv ====
// Operation
// - Offset 0: bit0 reconfigure, bit1 watchdog reset
// - Offset 0 strobes leave in the write cycle
// - Only a written one starts an operation
// - Reserved bits read zero, master writes zero
// - Offset 1 loads override flag and image select
// - Busy rises after offset 1; writes then ignored
// - Offset 2 bits start four readbacks, busy rises
// - Offset 3 bit0 reports busy
// - While busy only watchdog reset is honoured
// - Offset 4: watchdog value, enable, state code
// - Watchdog value is top 12 of 29 bits
// - Offset 5: application 1 source and state
// - Offset 6: application 2 source and state
// - Offset 7 returns input register, not pin
// - Upgrade block clock is half input clock

`timescale 1ns/100ps
`include "reconfig_cfg.svh"

module dual_image_reconfig_control import reconfig_pkg::*; (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Register slave port
  input  wire logic [2:0]  address,
  input  wire logic        write,
  input  wire logic        read,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  // Upgrade block strobes
  output logic             reconfig_strobe,
  output logic             watchdog_reset_strobe,
  // Upgrade block serial port
  output logic             upgrade_block_clock,
  output logic             link_shift,
  output logic             link_capture,
  output logic             link_din,
  output logic [1:0]       link_reg_sel,
  input  wire logic        link_dout
);

  xfer_if x ();

  logic [`RB_W:0]             pend_ff;
  logic [`RB_W:0]             nxt_pend;
  logic                       busy_ff;
  logic                       nxt_busy;
  logic [`SEL_W-1:0]          sel_wr_ff;
  op_t                        cur_ff;
  logic [`WD_FIELD_W-1:0]     wd_ff;
  logic [`PREV_W-1:0]         prev_one_ff;
  logic [`PREV_W-1:0]         prev_two_ff;
  logic [`SEL_W-1:0]          sel_rd_ff;
  logic [31:0]                readdata_ff;
  logic [31:0]                nxt_readdata;

  // Lowest set bit of the pending mask, write first
  function automatic op_t pick_op(input logic [`RB_W:0] p);
    op_t o;
    o = OP_RD_WD;
    if (p[`RB_W])             o = OP_WR_INPUT;
    else if (p[`RB_WATCHDOG]) o = OP_RD_WD;
    else if (p[`RB_PREV_TWO]) o = OP_RD_PREV2;
    else if (p[`RB_PREV_ONE]) o = OP_RD_PREV1;
    else if (p[`RB_INPUT])    o = OP_RD_INPUT;
    return o;
  endfunction : pick_op

  // Pending mask bit that belongs to an operation
  function automatic logic [`RB_W:0] op_bit(input op_t o);
    logic [`RB_W:0] m;
    m = '0;
    case (o)
      OP_WR_INPUT: m[`RB_W]        = 1'b1;
      OP_RD_WD:    m[`RB_WATCHDOG] = 1'b1;
      OP_RD_PREV2: m[`RB_PREV_TWO] = 1'b1;
      OP_RD_PREV1: m[`RB_PREV_ONE] = 1'b1;
      OP_RD_INPUT: m[`RB_INPUT]    = 1'b1;
      default:     m               = '0;
    endcase
    return m;
  endfunction : op_bit

  // Address decode
  wire wr_go     = ce & write;
  wire wr_trig   = wr_go & (address == `OFF_TRIGGER);
  wire wr_sel    = wr_go & (address == `OFF_SEL_WRITE) & ~busy_ff;
  wire wr_rb     = wr_go & (address == `OFF_READBACK) & ~busy_ff;
  wire rd_go     = ce & read;

  // Strobes go out in the bus write cycle itself
  assign reconfig_strobe       = wr_trig & writedata[`BIT_RECONFIG] & ~busy_ff;
  assign watchdog_reset_strobe = wr_trig & writedata[`BIT_WD_RESET];

  // New work requested this cycle; a zero bit starts nothing
  wire [`RB_W:0] req_new = {wr_sel, wr_rb ? writedata[`RB_W-1:0] : {`RB_W{1'b0}}};

  // Launch toward the serial engine
  op_t next_op;
  assign next_op    = pick_op(pend_ff);
  wire   launch     = ce & ~x.busy & ~x.done & (|pend_ff);
  assign x.start    = launch;
  assign x.op       = next_op;
  assign x.wdata    = {{(`XFER_LEN-`SEL_W){1'b0}}, sel_wr_ff};

  assign nxt_pend = (pend_ff & ~(launch ? op_bit(next_op) : {(`RB_W+1){1'b0}})) | req_new;
  assign nxt_busy = (|nxt_pend) | launch | (x.busy & ~x.done) | (x.busy & launch);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff   <= '0;
      busy_ff   <= 1'b0;
      sel_wr_ff <= '0;
      cur_ff    <= OP_RD_WD;
    end else if (ce) begin
      pend_ff <= nxt_pend;
      busy_ff <= nxt_busy;
      if (wr_sel) sel_wr_ff <= {writedata[`BIT_IMAGE], writedata[`BIT_OVERRIDE]};
      if (launch) cur_ff <= next_op;
    end
  end

  // Capture results when a readback completes
  wire done_rd = ce & x.done & ~cur_ff[2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_ff       <= '0;
      prev_one_ff <= '0;
      prev_two_ff <= '0;
      sel_rd_ff   <= '0;
    end else if (done_rd) begin
      case (cur_ff)
        OP_RD_WD:    wd_ff <= {x.rdata[`WD_STATE_HI:`WD_STATE_LO], x.rdata[`WD_EN_POS],
                               x.rdata[`WD_MSB_HI:`WD_MSB_LO]};
        OP_RD_PREV1: prev_one_ff <= x.rdata[`PREV_W-1:0];
        OP_RD_PREV2: prev_two_ff <= x.rdata[`PREV_W-1:0];
        OP_RD_INPUT: sel_rd_ff <= x.rdata[`SEL_W-1:0];
        default:     sel_rd_ff <= sel_rd_ff;
      endcase
    end
  end

  // Read data mux; reserved bits are zero
  always_comb begin
    nxt_readdata = 32'h0000_0000;
    case (address)
      `OFF_BUSY:     nxt_readdata = {31'h0000_0000, busy_ff};
      `OFF_WATCHDOG: nxt_readdata = {{(32-`WD_FIELD_W){1'b0}}, wd_ff};
      `OFF_PREV_ONE: nxt_readdata = {{(32-`PREV_W){1'b0}}, prev_one_ff};
      `OFF_PREV_TWO: nxt_readdata = {{(32-`PREV_W){1'b0}}, prev_two_ff};
      `OFF_SEL_READ: nxt_readdata = {{(32-`SEL_W){1'b0}}, sel_rd_ff};
      default:       nxt_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) readdata_ff <= 32'h0000_0000;
    else if (rd_go) readdata_ff <= nxt_readdata;
  end

  assign readdata = readdata_ff;

  upgrade_serial_engine u_engine (
    .clk                 (clk),
    .rst_n               (rst_n),
    .ce                  (ce),
    .x                   (x.engine),
    .upgrade_block_clock (upgrade_block_clock),
    .link_shift          (link_shift),
    .link_capture        (link_capture),
    .link_din            (link_din),
    .link_reg_sel        (link_reg_sel),
    .link_dout           (link_dout)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reconf_same_cycle: assert property (
    (ce && write && address == `OFF_TRIGGER && writedata[`BIT_RECONFIG] && !busy_ff) |-> reconfig_strobe)
    else $error("reconfig strobe missing in write cycle");

  a_reconf_busy_block: assert property (
    busy_ff |-> !reconfig_strobe)
    else $error("reconfig strobe issued while busy");

  a_wdrst_while_busy: assert property (
    (busy_ff && ce && write && address == `OFF_TRIGGER && writedata[`BIT_WD_RESET])
      |-> watchdog_reset_strobe)
    else $error("watchdog reset dropped while busy");

  a_busy_after_sel: assert property (
    (ce && write && address == `OFF_SEL_WRITE && !busy_ff) |=> busy_ff)
    else $error("busy did not rise after image select write");

  a_sel_write_ignored: assert property (
    (busy_ff && ce && write && address == `OFF_SEL_WRITE) |=> $stable(sel_wr_ff))
    else $error("image select changed while busy");

  a_busy_after_rb: assert property (
    (ce && write && address == `OFF_READBACK && (|writedata[`RB_W-1:0]) && !busy_ff) |=> busy_ff)
    else $error("busy did not rise after readback trigger");

  a_zero_no_op: assert property (
    (ce && write && address == `OFF_READBACK && writedata[`RB_W-1:0] == 4'h0 && !busy_ff && !x.busy)
      |=> !busy_ff)
    else $error("zero readback write started work");

  a_busy_read: assert property (
    (ce && read && address == `OFF_BUSY) |=> readdata == {31'h0000_0000, $past(busy_ff)})
    else $error("busy status read mismatch");

  a_wd_reserved_zero: assert property (
    (ce && read && address == `OFF_WATCHDOG) |=> (readdata[31:`WD_FIELD_W] == '0)
      && (readdata[`WD_FIELD_W-1:0] == $past(wd_ff)))
    else $error("watchdog read wrong or reserved bits set");

  a_sel_readback: assert property (
    (ce && read && address == `OFF_SEL_READ) |=> readdata == {30'h0000_0000, $past(sel_rd_ff)})
    else $error("image select readback mismatch");

  a_busy_fall_done: assert property (
    $fell(busy_ff) |-> $past(x.done))
    else $error("busy fell before transfer completed");

  // Strobe qualification
  a_reconf_needs_one: assert property (
    reconfig_strobe
      |-> (ce && write && address == `OFF_TRIGGER && writedata[`BIT_RECONFIG]))
    else $error("reconfig strobe without a written one");

  a_wdrst_needs_one: assert property (
    watchdog_reset_strobe
      |-> (ce && write && address == `OFF_TRIGGER && writedata[`BIT_WD_RESET]))
    else $error("watchdog strobe without a written one");

  a_wdrst_same_cycle: assert property (
    (ce && write && address == `OFF_TRIGGER && writedata[`BIT_WD_RESET])
      |-> watchdog_reset_strobe)
    else $error("watchdog strobe missing in write cycle");

  // Image select and readback queueing
  a_sel_load_value: assert property (
    (ce && write && address == `OFF_SEL_WRITE && !busy_ff)
      |=> (sel_wr_ff[`BIT_OVERRIDE] == $past(writedata[`BIT_OVERRIDE]))
          && (sel_wr_ff[`BIT_IMAGE] == $past(writedata[`BIT_IMAGE])))
    else $error("image select not loaded as written");

  a_sel_write_queued: assert property (
    (ce && write && address == `OFF_SEL_WRITE && !busy_ff)
      |=> pend_ff[`RB_W])
    else $error("image select write not queued");

  a_sel_busy_no_queue: assert property (
    (busy_ff && ce && write && address == `OFF_SEL_WRITE)
      |=> (!pend_ff[`RB_W] || $past(pend_ff[`RB_W])))
    else $error("image select write queued while busy");

  a_rb_queued: assert property (
    (ce && write && address == `OFF_READBACK && !busy_ff)
      |=> (pend_ff[`RB_W-1:0] == $past(writedata[`RB_W-1:0])))
    else $error("readback bits not queued as written");

  a_rb_busy_no_queue: assert property (
    (busy_ff && ce && write && address == `OFF_READBACK)
      |=> ((pend_ff[`RB_W-1:0] & ~$past(pend_ff[`RB_W-1:0])) == '0))
    else $error("readback queued while busy");

  // Busy bookkeeping
  a_pend_means_busy: assert property (
    (|pend_ff) |-> busy_ff)
    else $error("work pending while not busy");

  a_engine_means_busy: assert property (
    x.busy |-> busy_ff)
    else $error("transfer running while not busy");

  a_done_when_idle: assert property (
    x.done |-> !x.busy)
    else $error("transfer done while engine busy");

  a_busy_after_launch: assert property (
    x.start |=> (busy_ff && x.busy))
    else $error("launched transfer not busy");

  a_fall_all_served: assert property (
    $fell(busy_ff) |-> ((pend_ff == '0) && !x.busy))
    else $error("busy fell with work outstanding");

  a_idle_link_quiet: assert property (
    !busy_ff |-> (!link_shift && !link_capture))
    else $error("link active while not busy");

  a_link_sel_write: assert property (
    (x.busy && cur_ff == OP_WR_INPUT) |-> (&link_reg_sel))
    else $error("input register write uses wrong select");

  a_link_sel_read: assert property (
    (x.busy && !cur_ff[2]) |-> (link_reg_sel == cur_ff[1:0]))
    else $error("readback uses wrong register select");

  // Result capture and read-back
  a_wd_capture: assert property (
    (done_rd && cur_ff == OP_RD_WD)
      |=> (wd_ff == {$past(x.rdata[`WD_STATE_HI:`WD_STATE_LO]), $past(x.rdata[`WD_EN_POS]),
                     $past(x.rdata[`WD_MSB_HI:`WD_MSB_LO])}))
    else $error("watchdog word captured wrongly");

  a_wd_hold: assert property (
    !(done_rd && cur_ff == OP_RD_WD)
      |=> $stable(wd_ff))
    else $error("watchdog word changed without readback");

  a_prev_one_capture: assert property (
    (done_rd && cur_ff == OP_RD_PREV1) |=> (prev_one_ff == $past(x.rdata[`PREV_W-1:0])))
    else $error("previous state one captured wrongly");

  a_prev_two_capture: assert property (
    (done_rd && cur_ff == OP_RD_PREV2) |=> (prev_two_ff == $past(x.rdata[`PREV_W-1:0])))
    else $error("previous state two captured wrongly");

  a_input_capture: assert property (
    (done_rd && cur_ff == OP_RD_INPUT) |=> (sel_rd_ff == $past(x.rdata[`SEL_W-1:0])))
    else $error("input register captured wrongly");

  a_sel_rd_hold: assert property (
    !(done_rd && cur_ff == OP_RD_INPUT)
      |=> $stable(sel_rd_ff))
    else $error("select readback changed without readback");

  a_prev_one_read: assert property (
    (ce && read && address == `OFF_PREV_ONE)
      |=> (readdata == {{(32-`PREV_W){1'b0}}, $past(prev_one_ff)}))
    else $error("previous state one read mismatch");

  a_prev_two_read: assert property (
    (ce && read && address == `OFF_PREV_TWO)
      |=> (readdata == {{(32-`PREV_W){1'b0}}, $past(prev_two_ff)}))
    else $error("previous state two read mismatch");

  a_wo_reads_zero: assert property (
    (ce && read && (address == `OFF_TRIGGER || address == `OFF_SEL_WRITE || address == `OFF_READBACK))
      |=> (readdata == 32'h0000_0000))
    else $error("write-only offset read not zero");

endmodule : dual_image_reconfig_control

// ==== tb/upgrade_block_model.sv ====
`timescale 1ns/100ps
module upgrade_block_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial port
  input  wire logic        upgrade_block_clock,
  input  wire logic        link_shift,
  input  wire logic        link_capture,
  input  wire logic        link_din,
  input  wire logic [1:0]  link_reg_sel,
  output logic             link_dout,
  // Stored status
  input  wire logic [28:0] wd_count,
  input  wire logic        wd_en,
  input  wire logic [3:0]  wd_state,
  input  wire logic [7:0]  prev_one,
  input  wire logic [7:0]  prev_two,
  output logic      [1:0]  input_reg
);
  logic [33:0] sh_ff;
  logic        cap_seen_ff;
  logic        shift_d_ff;
  logic [33:0] frame;

  // Frame loaded for the selected register
  assign frame = (link_reg_sel == 2'h0) ? {wd_state, wd_en, wd_count} :
                 (link_reg_sel == 2'h1) ? {26'h0, prev_two} :
                 (link_reg_sel == 2'h2) ? {26'h0, prev_one} :
                 {32'h0, input_reg};
  // Line outside a frame shows the inverse of the last bit
  assign link_dout = link_capture ? sh_ff[0] : ~sh_ff[0];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_ff <= '0;
      cap_seen_ff <= 1'b0;
      shift_d_ff <= 1'b0;
      input_reg <= 2'h0;
    end else if (upgrade_block_clock) begin
      shift_d_ff <= link_shift;
      if (link_capture && !link_shift) begin
        sh_ff <= frame;
        cap_seen_ff <= 1'b1;
      end else if (link_shift) begin
        sh_ff <= {link_din, sh_ff[33:1]};
      end else begin
        cap_seen_ff <= 1'b0;
        // Update step after a frame without capture
        if (shift_d_ff && !cap_seen_ff && link_reg_sel == 2'h3) begin
          input_reg <= sh_ff[1:0];
        end
      end
    end
  end
endmodule : upgrade_block_model

// ==== tb/dual_image_reconfig_control_test.sv ====
`timescale 1ns/100ps
module dual_image_reconfig_control_test;
  logic        clk, rst_n, ce, write, read;
  logic [2:0]  address;
  logic [31:0] writedata, readdata, v;
  logic        reconfig_strobe, watchdog_reset_strobe;
  logic        upgrade_block_clock, link_shift, link_capture, link_din, link_dout;
  logic [1:0]  link_reg_sel, input_reg, sel;
  logic [28:0] wd_count;
  logic        wd_en, ubc_last, ce_last, trk_ok;
  logic [3:0]  wd_state;
  logic [7:0]  prev_one, prev_two;
  int          err_total, compares, seed, i;

  dual_image_reconfig_control i_dual_image_reconfig_control (.clk(clk), .rst_n(rst_n), .ce(ce),
    .address(address), .write(write), .read(read), .writedata(writedata), .readdata(readdata),
    .reconfig_strobe(reconfig_strobe), .watchdog_reset_strobe(watchdog_reset_strobe),
    .upgrade_block_clock(upgrade_block_clock), .link_shift(link_shift), .link_capture(link_capture),
    .link_din(link_din), .link_reg_sel(link_reg_sel), .link_dout(link_dout));
  upgrade_block_model i_upgrade_block_model (.clk(clk), .rst_n(rst_n),
    .upgrade_block_clock(upgrade_block_clock), .link_shift(link_shift), .link_capture(link_capture),
    .link_din(link_din), .link_reg_sel(link_reg_sel), .link_dout(link_dout), .wd_count(wd_count),
    .wd_en(wd_en), .wd_state(wd_state), .prev_one(prev_one), .prev_two(prev_two),
    .input_reg(input_reg));

  always #12.5 clk = ~clk;

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [31:0] d, input logic rc, input logic wd);
    address = a;
    writedata = d;
    write = 1'b1;
    read = 1'b0;
    #1;
    chk("reconfig strobe", {31'h0, rc}, {31'h0, reconfig_strobe});
    chk("watchdog strobe", {31'h0, wd}, {31'h0, watchdog_reset_strobe});
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    address = a;
    read = 1'b1;
    write = 1'b0;
    @(negedge clk);
    d = readdata;
  endtask : rd

  task automatic wait_idle;
    logic [31:0] b;
    int          n;
    n = 0;
    b = 32'h1;
    while (b[0] !== 1'b0 && n < 1000) begin
      rd(3'h3, b);
      n++;
    end
    chk("busy word", 32'h0, b);
  endtask : wait_idle

  function automatic logic [31:0] exp_wd();
    return {15'h0, wd_state, wd_en, wd_count[28:17]};
  endfunction : exp_wd

  // Link clock follows every enabled edge, stands while disabled
  always @(posedge clk) begin
    if (trk_ok && rst_n) begin
      chk("link clock", {31'h0, ubc_last ^ ce_last}, {31'h0, upgrade_block_clock});
    end
    trk_ok <= rst_n;
    ubc_last <= upgrade_block_clock;
    ce_last <= ce;
  end

  // Watchdog, about thirteen times the expected run
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    write = 1'b0;
    read = 1'b0;
    address = 3'h0;
    writedata = 32'h0;
    wd_count = 29'h0;
    wd_en = 1'b0;
    wd_state = 4'h0;
    prev_one = 8'h0;
    prev_two = 8'h0;
    trk_ok = 1'b0;
    err_total = 0;
    compares = 0;
    seed = $urandom(85524);
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    rd(3'h3, v);
    chk("busy after reset", 32'h0, v);
    wr(3'h0, 32'h3, 1'b1, 1'b1);
    wr(3'h0, $urandom & 32'hffff_fffc, 1'b0, 1'b0);
    wr(3'h2, 32'h0, 1'b0, 1'b0);
    rd(3'h3, v);
    chk("busy after zero write", 32'h0, v);
    for (i = 0; i < 4; i++) begin
      wd_count = 29'($urandom);
      wd_en = 1'($urandom);
      wd_state = 4'($urandom);
      prev_one = 8'($urandom);
      prev_two = 8'($urandom);
      sel = i[1:0];
      wr(3'h1, {30'h0, sel}, 1'b0, 1'b0);
      wr(3'h1, {30'h0, ~sel}, 1'b0, 1'b0);
      wr(3'h2, 32'hf, 1'b0, 1'b0);
      wr(3'h0, 32'h3, 1'b0, 1'b1);
      rd(3'h3, v);
      chk("busy after select write", 32'h1, v);
      wait_idle();
      chk("input register", {30'h0, sel}, {30'h0, input_reg});
      wr(3'h2, 32'hf, 1'b0, 1'b0);
      rd(3'h3, v);
      chk("busy after readback", 32'h1, v);
      wait_idle();
      rd(3'h4, v);
      chk("watchdog word", exp_wd(), v);
      rd(3'h5, v);
      chk("previous one", {24'h0, prev_one}, v);
      rd(3'h6, v);
      chk("previous two", {24'h0, prev_two}, v);
      rd(3'h7, v);
      chk("select readback", {30'h0, sel}, v);
    end
    read = 1'b0;
    @(negedge clk);
    ce = 1'b0;
    repeat (3) @(negedge clk);
    ce = 1'b1;
    repeat (3) @(negedge clk);
    end_of_test();
  end
endmodule : dual_image_reconfig_control_test
